// ===== hw/input_warn_and_status_bank.sv
// Purpose: input warning limits and status flag registers
// Assumes: one command per cycle on a parallel command port from the serial front end
// Notes: reads answer one cycle after the request; alert is a level
`timescale 1ns/10ps
module input_warn_and_status_bank #(
    parameter int LIMIT_W = warn_bank_pkg::LIMIT_W
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [1:0] cmd_size,
    input wire logic [15:0] cmd_wdata,
    input wire logic [LIMIT_W-1:0] input_voltage,
    input wire logic above_lockout_threshold,
    input wire logic switch_on,
    input wire logic power_good,
    input wire logic input_overvoltage_fault_cond,
    input wire logic input_overcurrent_fault_cond,
    input wire logic input_overcurrent_warning_cond,
    input wire logic input_overpower_warning_cond,
    input wire logic output_undervoltage_warning_cond,
    input wire logic overtemp_fault_cond,
    input wire logic overtemp_warning_cond,
    input wire logic comm_fault_cond,
    input wire logic vendor_specific_cond,
    output logic rsp_valid,
    output logic rsp_error,
    output logic [15:0] rsp_rdata,
    output logic alert_line
);
    localparam int NFLAG = 11;
    localparam int F_IN_UV_FAULT = 0;
    localparam int F_IN_UV_WARN = 1;
    localparam int F_IN_OV_WARN = 2;
    localparam int F_IN_OV_FAULT = 3;
    localparam int F_OC_FAULT = 4;
    localparam int F_OC_WARN = 5;
    localparam int F_OP_WARN = 6;
    localparam int F_OUT_UV_WARN = 7;
    localparam int F_OT_FAULT = 8;
    localparam int F_OT_WARN = 9;
    localparam int F_COMM = 10;

    typedef struct packed {
        logic [15:0] ov_limit;
        logic [15:0] uv_limit;
        logic seen_lockout;
        logic clear_pulse;
        logic vendor_flag;
        logic rsp_valid;
        logic rsp_error;
        logic [15:0] rsp_rdata;
        logic alert;
    } state_t;
    state_t s_q, s_d;

    logic ov_trip;
    logic uv_trip;
    logic [NFLAG-1:0] cond;
    logic [NFLAG-1:0] drop;
    logic [NFLAG-1:0] flag;
    logic [7:0] status_byte;
    logic [15:0] status_word;
    logic [7:0] output_status;
    logic [7:0] input_status;
    logic [7:0] temp_status;
    logic first_rise;

    if (LIMIT_W < 1 || LIMIT_W > 16) begin : g_bad_width
        $error("input_warn_and_status_bank: LIMIT_W must be 1..16");
    end

    // only commands taken by this bank are known here
    function automatic logic known_read(input logic [7:0] code);
        unique case (code)
            warn_bank_pkg::CMD_OV_WARN_LIMIT,
            warn_bank_pkg::CMD_UV_WARN_LIMIT,
            warn_bank_pkg::CMD_STATUS_BYTE,
            warn_bank_pkg::CMD_STATUS_WORD,
            warn_bank_pkg::CMD_OUTPUT_STATUS,
            warn_bank_pkg::CMD_INPUT_STATUS,
            warn_bank_pkg::CMD_TEMP_STATUS: known_read = 1'b1;
            default: known_read = 1'b0;
        endcase
    endfunction

    function automatic logic [1:0] size_of(input logic [7:0] code);
        unique case (code)
            warn_bank_pkg::CMD_OV_WARN_LIMIT,
            warn_bank_pkg::CMD_UV_WARN_LIMIT,
            warn_bank_pkg::CMD_STATUS_WORD: size_of = warn_bank_pkg::SIZE_WORD;
            default: size_of = warn_bank_pkg::SIZE_BYTE;
        endcase
    endfunction

    limit_compare #(
        .W(LIMIT_W),
        .ABOVE(1'b1),
        .DISABLE_CODE(warn_bank_pkg::OV_DISABLE_CODE[LIMIT_W-1:0])
    ) u_ov_cmp (
        .clock(clock),
        .rstn(rstn),
        .measured(input_voltage),
        .limit(s_q.ov_limit[LIMIT_W-1:0]),
        .tripped(ov_trip)
    );

    limit_compare #(
        .W(LIMIT_W),
        .ABOVE(1'b0),
        .DISABLE_CODE(warn_bank_pkg::UV_DISABLE_CODE[LIMIT_W-1:0])
    ) u_uv_cmp (
        .clock(clock),
        .rstn(rstn),
        .measured(input_voltage),
        .limit(s_q.uv_limit[LIMIT_W-1:0]),
        .tripped(uv_trip)
    );

    // startup UV flags drop on the first pass of the lockout level
    assign first_rise = above_lockout_threshold && !s_q.seen_lockout;

    always_comb begin
        cond = '0;
        cond[F_IN_UV_FAULT] = 1'b0;
        cond[F_IN_UV_WARN] = uv_trip;
        cond[F_IN_OV_WARN] = ov_trip;
        cond[F_IN_OV_FAULT] = input_overvoltage_fault_cond;
        cond[F_OC_FAULT] = input_overcurrent_fault_cond;
        cond[F_OC_WARN] = input_overcurrent_warning_cond;
        cond[F_OP_WARN] = input_overpower_warning_cond;
        cond[F_OUT_UV_WARN] = output_undervoltage_warning_cond;
        cond[F_OT_FAULT] = overtemp_fault_cond;
        cond[F_OT_WARN] = overtemp_warning_cond;
        cond[F_COMM] = comm_fault_cond;
        drop = '0;
        drop[F_IN_UV_FAULT] = first_rise;
        drop[F_IN_UV_WARN] = first_rise && !uv_trip;
    end

    genvar gi;
    generate
        for (gi = 0; gi < NFLAG; gi++) begin : g_flag
            sticky_flag #(
                .RESET_VALUE((gi == F_IN_UV_FAULT) || (gi == F_IN_UV_WARN))
            ) u_flag (
                .clock(clock),
                .rstn(rstn),
                .condition(cond[gi]),
                .clear(s_q.clear_pulse),
                .drop(drop[gi]),
                .flag(flag[gi])
            );
        end
    endgenerate

    always_comb begin
        output_status = '0;
        output_status[warn_bank_pkg::OS_UV_WARN] = flag[F_OUT_UV_WARN];
        input_status = '0;
        input_status[warn_bank_pkg::IS_OV_FAULT] = flag[F_IN_OV_FAULT];
        input_status[warn_bank_pkg::IS_OV_WARN] = flag[F_IN_OV_WARN];
        input_status[warn_bank_pkg::IS_UV_WARN] = flag[F_IN_UV_WARN];
        input_status[warn_bank_pkg::IS_UV_FAULT] = flag[F_IN_UV_FAULT];
        input_status[warn_bank_pkg::IS_OC_FAULT] = flag[F_OC_FAULT];
        input_status[warn_bank_pkg::IS_OC_WARN] = flag[F_OC_WARN];
        input_status[warn_bank_pkg::IS_OP_WARN] = flag[F_OP_WARN];
        temp_status = '0;
        temp_status[warn_bank_pkg::TS_OT_FAULT] = flag[F_OT_FAULT];
        temp_status[warn_bank_pkg::TS_OT_WARN] = flag[F_OT_WARN];
        status_byte = '0;
        status_byte[warn_bank_pkg::SB_OFF] = !switch_on;
        status_byte[warn_bank_pkg::SB_IN_UV_FAULT] = flag[F_IN_UV_FAULT];
        status_byte[warn_bank_pkg::SB_TEMP] = |temp_status;
        status_byte[warn_bank_pkg::SB_COMM] = flag[F_COMM];
        // catch-all: input flags, output UV warning and vendor events not shown above
        status_byte[warn_bank_pkg::SB_OTHER] = flag[F_IN_UV_WARN] | flag[F_IN_OV_WARN]
            | flag[F_IN_OV_FAULT] | flag[F_OC_FAULT] | flag[F_OC_WARN]
            | flag[F_OP_WARN] | flag[F_OUT_UV_WARN] | s_q.vendor_flag;
        status_word = '0;
        status_word[7:0] = status_byte;
        status_word[warn_bank_pkg::SW_OUTPUT] = |output_status;
        status_word[warn_bank_pkg::SW_INPUT] = |input_status;
        status_word[warn_bank_pkg::SW_VENDOR] = s_q.vendor_flag;
        status_word[warn_bank_pkg::SW_PG_N] = !power_good;
    end

    always_comb begin
        s_d = s_q;
        s_d.rsp_valid = 1'b0;
        s_d.rsp_error = 1'b0;
        s_d.clear_pulse = 1'b0;
        if (above_lockout_threshold) begin
            s_d.seen_lockout = 1'b1;
        end
        if (vendor_specific_cond) begin
            s_d.vendor_flag = 1'b1;
        end else if (s_q.clear_pulse) begin
            s_d.vendor_flag = 1'b0;
        end
        if (cmd_valid) begin
            s_d.rsp_valid = 1'b1;
            s_d.rsp_rdata = '0;
            if (cmd_write && cmd_code == warn_bank_pkg::CMD_CLEAR_FAULTS) begin
                s_d.clear_pulse = 1'b1;
            end else if (!known_read(cmd_code) || cmd_size != size_of(cmd_code)) begin
                s_d.rsp_error = 1'b1;
            end else if (cmd_write) begin
                if (cmd_code == warn_bank_pkg::CMD_OV_WARN_LIMIT) begin
                    s_d.ov_limit = {{(16 - LIMIT_W){1'b0}}, cmd_wdata[LIMIT_W-1:0]};
                end else if (cmd_code == warn_bank_pkg::CMD_UV_WARN_LIMIT) begin
                    s_d.uv_limit = {{(16 - LIMIT_W){1'b0}}, cmd_wdata[LIMIT_W-1:0]};
                end else begin
                    s_d.rsp_error = 1'b1;
                end
            end else begin
                unique case (cmd_code)
                    warn_bank_pkg::CMD_OV_WARN_LIMIT: s_d.rsp_rdata = s_q.ov_limit;
                    warn_bank_pkg::CMD_UV_WARN_LIMIT: s_d.rsp_rdata = s_q.uv_limit;
                    warn_bank_pkg::CMD_STATUS_BYTE: s_d.rsp_rdata = {8'h00, status_byte};
                    warn_bank_pkg::CMD_STATUS_WORD: s_d.rsp_rdata = status_word;
                    warn_bank_pkg::CMD_OUTPUT_STATUS: s_d.rsp_rdata = {8'h00, output_status};
                    warn_bank_pkg::CMD_INPUT_STATUS: s_d.rsp_rdata = {8'h00, input_status};
                    warn_bank_pkg::CMD_TEMP_STATUS: s_d.rsp_rdata = {8'h00, temp_status};
                    default: s_d.rsp_rdata = '0;
                endcase
            end
        end
        // alert follows stored warning and fault flags and the vendor flag; startup UV flags do not raise it
        s_d.alert = (|flag[NFLAG-1:F_IN_OV_WARN]) | (flag[F_IN_UV_WARN] & s_q.seen_lockout)
            | s_q.vendor_flag;
        if (s_q.clear_pulse) begin
            s_d.alert = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.ov_limit <= warn_bank_pkg::OV_LIMIT_RESET;
            s_q.uv_limit <= warn_bank_pkg::UV_LIMIT_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign rsp_valid = s_q.rsp_valid;
    assign rsp_error = s_q.rsp_error;
    assign rsp_rdata = s_q.rsp_rdata;
    assign alert_line = s_q.alert;
endmodule

// ===== hw/limit_compare.sv
// Purpose: compare one measurement against a limit with a disable code
// Assumes: measurement and limit share one scale
// Notes: registered result, one cycle behind the inputs
`timescale 1ns/10ps
module limit_compare #(
    parameter int W = 12,
    parameter bit ABOVE = 1'b1,
    parameter logic [W-1:0] DISABLE_CODE = '1
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [W-1:0] measured,
    input wire logic [W-1:0] limit,
    output logic tripped
);
    typedef struct packed {
        logic trip;
    } state_t;
    state_t s_q, s_d;

    // refused at elaboration, not at run time
    if (W < 1) begin : g_bad_width
        $error("limit_compare: width must be positive");
    end

    always_comb begin
        s_d = s_q;
        if (limit == DISABLE_CODE) begin
            s_d.trip = 1'b0;
        end else if (ABOVE) begin
            s_d.trip = measured > limit;
        end else begin
            s_d.trip = measured < limit;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tripped = s_q.trip;
endmodule

// ===== hw/sticky_flag.sv
// Purpose: one sticky status flag with a startup value
// Assumes: condition is a level, clear is a one-cycle pulse
// Notes: an active condition beats a clear in the same cycle
`timescale 1ns/10ps
module sticky_flag #(
    parameter bit RESET_VALUE = 1'b0
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic condition,
    input wire logic clear,
    input wire logic drop,
    output logic flag
);
    typedef struct packed {
        logic f;
    } state_t;
    state_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        if (condition) begin
            s_d.f = 1'b1;
        end else if (clear || drop) begin
            s_d.f = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            s_q <= RESET_VALUE;
        end else begin
            s_q <= s_d;
        end
    end

    assign flag = s_q.f;
endmodule

// ===== hw/warn_bank_pkg.sv
// Purpose: constants for the input warning and status register bank
// Assumes: command codes act as register offsets on a simple command port
// Notes: flag bit positions follow the status register layouts
// How it works
// - input over-voltage limit: 0x0fff disables, reset value 0x0fff.
// - input under-voltage limit: zero disables, reset value zero.
// - input below enabled under-voltage limit sets warning flags, and alert after first lockout pass.
// - status byte bit 6 reads one while the pass switch is off.
// - status byte bits 3,2,1,0: input UV fault, temp, comm, other.
// - unsupported status bits always read zero.
// - status word bits 15,13,12,11: output, input, vendor, not power good.
// - flags stay set until condition is gone and clear-faults issued.
// - input summary and UV fault flags start at one until first lockout pass.
// - input UV warning flag starts at one until first lockout pass.
// - output-voltage status implements only bit 5.
// - input status bit layout 7,6,5,4,2,1,0; bit 3 reads zero.
// - temperature status bits 7 and 6 only.
// - input above enabled over-voltage limit sets warning flags and alert.
// - clear-faults resets stored flags and alert; persisting ones set again.
package warn_bank_pkg;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_OV_WARN_LIMIT = 8'h57;
    localparam logic [7:0] CMD_UV_WARN_LIMIT = 8'h58;
    localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
    localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
    localparam logic [7:0] CMD_OUTPUT_STATUS = 8'h7a;
    localparam logic [7:0] CMD_INPUT_STATUS = 8'h7c;
    localparam logic [7:0] CMD_TEMP_STATUS = 8'h7d;
    localparam logic [15:0] OV_LIMIT_RESET = 16'h0fff;
    localparam logic [15:0] UV_LIMIT_RESET = 16'h0000;
    localparam logic [11:0] OV_DISABLE_CODE = 12'hfff;
    localparam logic [11:0] UV_DISABLE_CODE = 12'h000;
    localparam int LIMIT_W = 12;
    // status byte positions
    localparam int SB_OFF = 6;
    localparam int SB_IN_UV_FAULT = 3;
    localparam int SB_TEMP = 2;
    localparam int SB_COMM = 1;
    localparam int SB_OTHER = 0;
    // status word upper positions
    localparam int SW_OUTPUT = 15;
    localparam int SW_INPUT = 13;
    localparam int SW_VENDOR = 12;
    localparam int SW_PG_N = 11;
    // output status
    localparam int OS_UV_WARN = 5;
    // input status
    localparam int IS_OV_FAULT = 7;
    localparam int IS_OV_WARN = 6;
    localparam int IS_UV_WARN = 5;
    localparam int IS_UV_FAULT = 4;
    localparam int IS_OC_FAULT = 2;
    localparam int IS_OC_WARN = 1;
    localparam int IS_OP_WARN = 0;
    // temperature status
    localparam int TS_OT_FAULT = 7;
    localparam int TS_OT_WARN = 6;
    // transfer sizes on the command port
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
endpackage

// ===== tb/input_warn_and_status_bank_properties.sv
// Purpose: port checks for the input warning and status bank
// Assumes: answers come one cycle after the command edge
// Notes: reads are qualified by their legal size only
`timescale 1ns/10ps
module input_warn_and_status_bank_properties #(
    parameter int LIMIT_W = warn_bank_pkg::LIMIT_W
) (
    input wire logic clock, rstn, cmd_valid, cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [1:0] cmd_size,
    input wire logic [15:0] cmd_wdata,
    input wire logic [LIMIT_W-1:0] input_voltage,
    input wire logic above_lockout_threshold, switch_on, power_good,
    input wire logic input_overvoltage_fault_cond, input_overcurrent_fault_cond,
    input wire logic input_overcurrent_warning_cond, input_overpower_warning_cond,
    input wire logic output_undervoltage_warning_cond, overtemp_fault_cond,
    input wire logic overtemp_warning_cond, comm_fault_cond, vendor_specific_cond,
    input wire logic rsp_valid, rsp_error,
    input wire logic [15:0] rsp_rdata,
    input wire logic alert_line
);
    logic rd_b;
    logic rd_w;
    logic clr;
    assign rd_b = cmd_valid && !cmd_write && cmd_size == warn_bank_pkg::SIZE_BYTE;
    assign rd_w = cmd_valid && !cmd_write && cmd_size == warn_bank_pkg::SIZE_WORD;
    assign clr = cmd_valid && cmd_write && cmd_code == warn_bank_pkg::CMD_CLEAR_FAULTS;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    a_answer_follows: assert property (cmd_valid |=> rsp_valid)
        else $error("command without answer");
    a_no_stray_answer: assert property (!cmd_valid |=> !rsp_valid && !rsp_error)
        else $error("answer without command");
    a_byte_unsupported: assert property (
        rd_b && cmd_code == warn_bank_pkg::CMD_STATUS_BYTE
        |=> rsp_rdata[15:7] == 9'h000 && rsp_rdata[5:4] == 2'h0) else $error("status byte spare");
    a_word_unsupported: assert property (
        rd_w && cmd_code == warn_bank_pkg::CMD_STATUS_WORD |=> rsp_rdata[14] == 1'b0
        && rsp_rdata[10:7] == 4'h0 && rsp_rdata[5:4] == 2'h0) else $error("status word spare");
    a_outstat_only_bit5: assert property (
        rd_b && cmd_code == warn_bank_pkg::CMD_OUTPUT_STATUS
        |=> {rsp_rdata[15:6], rsp_rdata[4:0]} == 15'h0000) else $error("output status spare");
    a_input_bit3_zero: assert property (
        rd_b && cmd_code == warn_bank_pkg::CMD_INPUT_STATUS
        |=> rsp_rdata[3] == 1'b0 && rsp_rdata[15:8] == 8'h00) else $error("input status spare");
    a_temp_low_zero: assert property (
        rd_b && cmd_code == warn_bank_pkg::CMD_TEMP_STATUS
        |=> rsp_rdata[5:0] == 6'h00) else $error("temperature status spare");
    a_off_bit_set: assert property (
        (!switch_on)[*3] ##0 (rd_b && cmd_code == warn_bank_pkg::CMD_STATUS_BYTE)
        |=> rsp_rdata[6]) else $error("switch off bit low");
    a_alert_sticky: assert property (
        alert_line && !clr && !$past(clr) |=> alert_line) else $error("alert dropped alone");
    c_clear: cover property (clr ##2 !alert_line);
    c_alert: cover property ($rose(alert_line));
    c_refused: cover property (rsp_error);
endmodule
bind input_warn_and_status_bank input_warn_and_status_bank_properties #(.LIMIT_W(LIMIT_W)) i_props (
    .clock(clock), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_size(cmd_size), .cmd_wdata(cmd_wdata),
    .input_voltage(input_voltage), .above_lockout_threshold(above_lockout_threshold),
    .switch_on(switch_on), .power_good(power_good),
    .input_overvoltage_fault_cond(input_overvoltage_fault_cond),
    .input_overcurrent_fault_cond(input_overcurrent_fault_cond),
    .input_overcurrent_warning_cond(input_overcurrent_warning_cond),
    .input_overpower_warning_cond(input_overpower_warning_cond),
    .output_undervoltage_warning_cond(output_undervoltage_warning_cond),
    .overtemp_fault_cond(overtemp_fault_cond), .overtemp_warning_cond(overtemp_warning_cond),
    .comm_fault_cond(comm_fault_cond), .vendor_specific_cond(vendor_specific_cond),
    .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_rdata(rsp_rdata),
    .alert_line(alert_line));

// ===== tb/input_warn_and_status_bank_tb_top.sv
// Purpose: self-checking bench for the input warning and status bank
// Assumes: host model owns the command port, bench owns the condition inputs
// Notes: random limits come from a fixed-seed shift register
`timescale 1ns/10ps
module input_warn_and_status_bank_tb_top;
    logic clock, rstn, cmd_valid, cmd_write, rsp_valid, rsp_error, alert_line, err;
    logic lock_ok, sw_on, pg;
    logic [7:0] cmd_code;
    logic [1:0] cmd_size;
    logic [15:0] cmd_wdata, rsp_rdata, rd, b, m;
    logic [11:0] vin, lim;
    logic [8:0] cond;
    logic [31:0] seed;
    int fail_count;
    int n_compared;
    input_warn_and_status_bank i_input_warn_and_status_bank (.clock(clock), .rstn(rstn),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_size(cmd_size),
        .cmd_wdata(cmd_wdata), .input_voltage(vin), .above_lockout_threshold(lock_ok),
        .switch_on(sw_on), .power_good(pg), .input_overvoltage_fault_cond(cond[0]),
        .input_overcurrent_fault_cond(cond[1]), .input_overcurrent_warning_cond(cond[2]),
        .input_overpower_warning_cond(cond[3]), .output_undervoltage_warning_cond(cond[4]),
        .overtemp_fault_cond(cond[5]), .overtemp_warning_cond(cond[6]),
        .comm_fault_cond(cond[7]), .vendor_specific_cond(cond[8]), .rsp_valid(rsp_valid),
        .rsp_error(rsp_error), .rsp_rdata(rsp_rdata), .alert_line(alert_line));
    mgmt_host_model i_mgmt_host_model (.clock(clock), .rsp_valid(rsp_valid),
        .rsp_error(rsp_error), .rsp_rdata(rsp_rdata), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_size(cmd_size), .cmd_wdata(cmd_wdata));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // per condition: register code, register bit, status word bit
    function automatic logic [15:0] cond_map(input int i);
        logic [15:0] t [9] = '{16'h7c7d, 16'h7c2d, 16'h7c1d, 16'h7c0d, 16'h7a5f,
            16'h7d72, 16'h7d62, 16'h7811, 16'h79cc};
        return t[i];
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] mk);
        n_compared++;
        if ((got & mk) !== (exp & mk)) begin
            fail_count++;
            $display("ERROR %0t: data %h want %h mask %h", $time, got, exp, mk);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: flag %b want %b", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] c, input logic [15:0] mk, input logic [15:0] e);
        i_mgmt_host_model.xfer(1'b0, c, 16'h0000, 1'b0, rd, err);
        chk_bit(err, 1'b0);
        chk(rd, e, mk);
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        i_mgmt_host_model.xfer(1'b1, c, d, 1'b0, rd, err);
        chk_bit(err, 1'b0);
    endtask
    task automatic apply(input logic [11:0] v, input logic [8:0] c);
        @(posedge clock);
        vin <= v;
        cond <= c;
        repeat (5) @(posedge clock);
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // whole run is under five hundred cycles
    initial begin
        #400000;
        fail_count++;
        $display("ERROR %0t: watchdog expired", $time);
        end_of_test();
    end
    initial begin
        {rstn, lock_ok, sw_on, pg, cond} = 13'h0000;
        vin = 12'h800;
        seed = 32'h0001_7279;
        fail_count = 0;
        n_compared = 0;
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        rdc(warn_bank_pkg::CMD_OV_WARN_LIMIT, 16'hffff, 16'h0fff);
        rdc(warn_bank_pkg::CMD_UV_WARN_LIMIT, 16'hffff, 16'h0000);
        rdc(warn_bank_pkg::CMD_STATUS_WORD, 16'h2048, 16'h2048);
        rdc(warn_bank_pkg::CMD_INPUT_STATUS, 16'h0020, 16'h0020);
        $display("done startup defaults");
        @(posedge clock);
        lock_ok <= 1'b1;
        sw_on <= 1'b1;
        pg <= 1'b1;
        apply(12'h800, 9'h000);
        rdc(warn_bank_pkg::CMD_STATUS_WORD, 16'h2008, 16'h0000);
        rdc(warn_bank_pkg::CMD_INPUT_STATUS, 16'h0020, 16'h0000);
        wr(warn_bank_pkg::CMD_CLEAR_FAULTS, 16'h0000);
        rdc(warn_bank_pkg::CMD_STATUS_WORD, 16'h0840, 16'h0000);
        chk_bit(alert_line, 1'b0);
        $display("done lockout pass");
        wr(warn_bank_pkg::CMD_UV_WARN_LIMIT, 16'h0100);
        apply(12'h0ff, 9'h000);
        rdc(warn_bank_pkg::CMD_STATUS_WORD, 16'h2000, 16'h2000);
        chk_bit(alert_line, 1'b1);
        apply(12'h100, 9'h000);
        rdc(warn_bank_pkg::CMD_INPUT_STATUS, 16'h0020, 16'h0020);
        wr(warn_bank_pkg::CMD_CLEAR_FAULTS, 16'h0000);
        rdc(warn_bank_pkg::CMD_INPUT_STATUS, 16'h0020, 16'h0000);
        chk_bit(alert_line, 1'b0);
        apply(12'h0ff, 9'h000);
        wr(warn_bank_pkg::CMD_CLEAR_FAULTS, 16'h0000);
        rdc(warn_bank_pkg::CMD_INPUT_STATUS, 16'h0020, 16'h0020);
        wr(warn_bank_pkg::CMD_UV_WARN_LIMIT, 16'h0000);
        apply(12'h000, 9'h000);
        wr(warn_bank_pkg::CMD_CLEAR_FAULTS, 16'h0000);
        rdc(warn_bank_pkg::CMD_INPUT_STATUS, 16'h0020, 16'h0000);
        $display("done under-voltage warning");
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            lim = (i == 0) ? 12'hffe : 12'h800 + {2'h0, seed[9:0]};
            wr(warn_bank_pkg::CMD_OV_WARN_LIMIT, {4'h0, lim});
            apply(lim, 9'h000);
            wr(warn_bank_pkg::CMD_CLEAR_FAULTS, 16'h0000);
            rdc(warn_bank_pkg::CMD_INPUT_STATUS, 16'h0040, 16'h0000);
            apply(lim + 12'h001, 9'h000);
            rdc(warn_bank_pkg::CMD_INPUT_STATUS, 16'h0040, 16'h0040);
            chk_bit(alert_line, 1'b1);
            rdc(warn_bank_pkg::CMD_OV_WARN_LIMIT, 16'hffff, {4'h0, lim});
        end
        wr(warn_bank_pkg::CMD_OV_WARN_LIMIT, 16'h0fff);
        apply(12'hfff, 9'h000);
        wr(warn_bank_pkg::CMD_CLEAR_FAULTS, 16'h0000);
        rdc(warn_bank_pkg::CMD_INPUT_STATUS, 16'h0040, 16'h0000);
        $display("done over-voltage warning");
        for (int i = 0; i < 9; i++) begin
            m = cond_map(i);
            apply(12'h800, 9'h001 << i);
            rdc(m[15:8], 16'h0001 << m[7:4], 16'hffff);
            rdc(warn_bank_pkg::CMD_STATUS_WORD, 16'h0001 << m[3:0], 16'hffff);
            rdc(warn_bank_pkg::CMD_STATUS_BYTE, 16'h0000, 16'h0000);
            b = rd;
            rdc(warn_bank_pkg::CMD_STATUS_WORD, 16'h00ff, b);
            apply(12'h800, 9'h000);
            wr(warn_bank_pkg::CMD_CLEAR_FAULTS, 16'h0000);
            rdc(m[15:8], 16'h0001 << m[7:4], 16'h0000);
        end
        $display("done condition table");
        i_mgmt_host_model.xfer(1'b1, warn_bank_pkg::CMD_STATUS_BYTE, 16'h00ff, 1'b0, rd, err);
        chk_bit(err, 1'b1);
        i_mgmt_host_model.xfer(1'b1, warn_bank_pkg::CMD_UV_WARN_LIMIT, 16'h0123, 1'b1, rd, err);
        chk_bit(err, 1'b1);
        i_mgmt_host_model.xfer(1'b0, 8'hff, 16'h0000, 1'b0, rd, err);
        chk_bit(err, 1'b1);
        rdc(warn_bank_pkg::CMD_UV_WARN_LIMIT, 16'hffff, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            wr(warn_bank_pkg::CMD_UV_WARN_LIMIT, seed[15:0]);
            rdc(warn_bank_pkg::CMD_UV_WARN_LIMIT, 16'hffff, {4'h0, seed[11:0]});
        end
        @(posedge clock);
        sw_on <= 1'b0;
        apply(12'hfff, 9'h000);
        rdc(warn_bank_pkg::CMD_STATUS_BYTE, 16'h0040, 16'h0040);
        $display("done refusals and readback");
        end_of_test();
    end
endmodule

// ===== tb/mgmt_host_model.sv
// Purpose: management host on the bank's command port
// Assumes: one command in flight, answer within four cycles
// Notes: bad flips the size to provoke a refusal; idle code and data show inverted junk
`timescale 1ns/10ps
module mgmt_host_model (
    input wire logic clock,
    input wire logic rsp_valid,
    input wire logic rsp_error,
    input wire logic [15:0] rsp_rdata,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [1:0] cmd_size,
    output logic [15:0] cmd_wdata
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_size = 2'h0;
        cmd_wdata = 16'h0000;
    end
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
            input logic bad, output logic [15:0] rd, output logic err);
        logic word;
        word = code inside {warn_bank_pkg::CMD_OV_WARN_LIMIT, warn_bank_pkg::CMD_UV_WARN_LIMIT,
            warn_bank_pkg::CMD_STATUS_WORD};
        rd = 16'hxxxx;
        err = 1'bx;
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_code <= code;
        cmd_size <= (word ^ bad) ? warn_bank_pkg::SIZE_WORD : warn_bank_pkg::SIZE_BYTE;
        cmd_wdata <= wd;
        @(posedge clock);
        cmd_valid <= 1'b0;
        cmd_code <= ~code;
        cmd_wdata <= ~wd;
        for (int i = 0; i < 4; i++) begin
            #1;
            if (rsp_valid === 1'b1) begin
                rd = rsp_rdata;
                err = rsp_error;
                break;
            end
            @(posedge clock);
        end
    endtask
endmodule
